// ==== core/dcc_engine.sv ====
// Calibration correction engine with its register file and Avalon-MM slave.
// Assumes a synchronous Avalon-MM master and a static format strap pin.
`timescale 1ns/100ps

// Summary of operation
// - Enabled engine corrects input by channel gain and zero into data.
// - While enabled, any input, gain or zero write recomputes and stores that channel.
// - Result is input times (gain plus 2048) over 4096, plus zero.
// - Gain code spans coefficient 0.5 to 1.5.
// - Zero code is signed, -2048 to +2047 LSB.
// - One engine serves all eight channels, one at a time.
// - Config enable bit: 0 turns engine off, 1 turns it on.
// - Engine off: written input goes straight to data register.
// - Engine off: gain and zero writes store only, read back unchanged.
// - Each channel owns its own gain and zero registers.
// - Reset: gain 2048, zero 0, input 000h.
// - Group shift codes reset to trimmed defaults per group and gain.
// - Channels 0-3 form group A, channels 4-7 group B.
// - Config gain select bit picks amplifier gain six or four.
// - Each channel's 12-bit data code selects its string tap.
// - Gain is straight binary, zero twos complement, whatever the pin.
// - Format pin low: binary input and shift; high: twos complement.
// - Read-back returns input and shift in the format written, data codes in straight binary.
// - Changing gain select reloads shift codes with the new default.
module dcc_engine #(
   parameter logic [11:0] SHIFT_A_G6 = dcc_pkg::SHIFT_G6_DEFAULT,
   parameter logic [11:0] SHIFT_A_G4 = dcc_pkg::SHIFT_G4_DEFAULT,
   parameter logic [11:0] SHIFT_B_G6 = dcc_pkg::SHIFT_G6_DEFAULT,
   parameter logic [11:0] SHIFT_B_G4 = dcc_pkg::SHIFT_G4_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register bus
   input wire dcc_pkg::dcc_avs_req_type avs_req,
   output dcc_pkg::dcc_avs_rsp_type avs_rsp,
   // Format strap
   input wire logic format_select_pin,
   // Converter side
   output dcc_pkg::dcc_conv_type conv
);

   // -----------------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------------
   // Converts a code in the pin-selected format to straight binary and back.
   function automatic logic [11:0] dcc_fmt(logic [11:0] c, logic btc);
      return {c[11] ^ btc, c[10:0]};
   endfunction

   function automatic logic [11:0] dcc_correct(logic [11:0] code,
                                               logic [11:0] gain,
                                               logic [11:0] zero);
      logic [24:0] prod;
      logic signed [14:0] sum;
      prod = 25'(code) * 25'({1'b0, gain} + dcc_pkg::GAIN_BIAS);
      sum = signed'({2'b00, prod[24:12]})
            + signed'({{3{zero[11]}}, zero});
      if (sum < 0) begin
         return 12'h000;
      end else if (sum > signed'({3'b000, dcc_pkg::CODE_MAX})) begin
         return dcc_pkg::CODE_MAX;
      end else begin
         return sum[11:0];
      end
   endfunction

   // -----------------------------------------------------------------------
   // State
   // -----------------------------------------------------------------------
   localparam int QW = dcc_pkg::QW;
   dcc_pkg::dcc_state_type q;
   dcc_pkg::dcc_state_type d;
   logic en;
   logic btc;
   logic wr_ok;
   logic [2:0] region;
   logic [2:0] wr_ch;
   logic [11:0] wd;
   logic chan_wr;
   logic pop;
   logic [2:0] pop_ch;
   logic [QW-1:0] cn;

   assign en = q.cfg[dcc_pkg::CFG_EN_BIT];
   assign btc = q.fmt_s2;
   assign region = avs_req.address[7:5];
   assign wr_ch = avs_req.address[4:2];
   assign wd = avs_req.writedata[11:0];
   assign wr_ok = avs_req.write && (avs_req.byteenable[1:0] == 2'h3)
                  && (avs_req.address[1:0] == 2'h0);
   assign chan_wr = wr_ok && !avs_req.address[7]
                    && (region != dcc_pkg::REGION_DATA);
   assign pop = (q.phase == dcc_pkg::DCC_IDLE) && (q.cnt != '0) && en;
   assign pop_ch = q.queue[0];

   // -----------------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------------
   always_comb begin
      d = q;
      cn = q.cnt;
      d.fmt_s1 = format_select_pin;
      d.fmt_s2 = q.fmt_s1;

      // Read path: one wait state, data registered.
      d.rvalid = avs_req.read && !q.rvalid;
      if (avs_req.read && !q.rvalid) begin
         d.rdata = 32'h0000_0000;
         if (!avs_req.address[7]) begin
            case (region)
               dcc_pkg::REGION_INPUT:
                  d.rdata[11:0] = q.input_raw[wr_ch];
               dcc_pkg::REGION_GAIN: d.rdata[11:0] = q.gain[wr_ch];
               dcc_pkg::REGION_ZERO: d.rdata[11:0] = q.zero[wr_ch];
               dcc_pkg::REGION_DATA: d.rdata[11:0] = q.data[wr_ch];
               default: d.rdata = 32'h0000_0000;
            endcase
         end else begin
            case (avs_req.address)
               dcc_pkg::ADDR_CONFIG: d.rdata[1:0] = q.cfg;
               dcc_pkg::ADDR_SHIFT_A: d.rdata[11:0] = dcc_fmt(q.shift_a, btc);
               dcc_pkg::ADDR_SHIFT_B: d.rdata[11:0] = dcc_fmt(q.shift_b, btc);
               dcc_pkg::ADDR_STATUS:
                  d.rdata[5:0] = {btc, q.cnt, q.phase == dcc_pkg::DCC_CALC};
               default: d.rdata = 32'h0000_0000;
            endcase
         end
      end

      // Engine: finish the channel taken last cycle.
      if (q.phase == dcc_pkg::DCC_CALC) begin
         d.data[q.cur_ch] = dcc_correct(dcc_fmt(q.input_raw[q.cur_ch], btc),
                                        q.gain[q.cur_ch],
                                        q.zero[q.cur_ch]);
         d.phase = dcc_pkg::DCC_IDLE;
      end

      // Engine: take the oldest queued channel.
      if (pop) begin
         for (int i = 0; i < dcc_pkg::NCH - 1; i++) begin
            d.queue[i] = q.queue[i + 1];
         end
         d.queue[dcc_pkg::NCH-1] = 3'h0;
         cn = cn - QW'(1);
         d.pend[pop_ch] = 1'b0;
         d.cur_ch = pop_ch;
         d.phase = dcc_pkg::DCC_CALC;
      end

      // Channel register writes.
      if (chan_wr) begin
         case (region)
            dcc_pkg::REGION_INPUT: begin
               d.input_raw[wr_ch] = wd;
               if (!en) begin
                  d.data[wr_ch] = dcc_fmt(wd, btc);
               end
            end
            dcc_pkg::REGION_GAIN: d.gain[wr_ch] = wd;
            dcc_pkg::REGION_ZERO: d.zero[wr_ch] = wd;
            default: d.cnt = cn;
         endcase
         // A channel already waiting is not queued twice: it reads the
         // newest register values when served, so no update is lost.
         if (en && !d.pend[wr_ch]) begin
            d.queue[cn[2:0]] = wr_ch;
            d.pend[wr_ch] = 1'b1;
            cn = cn + QW'(1);
         end
      end
      d.cnt = cn;

      // Global register writes.
      if (wr_ok) begin
         case (avs_req.address)
            dcc_pkg::ADDR_CONFIG: begin
               d.cfg = wd[1:0];
               if (wd[dcc_pkg::CFG_GAIN6_BIT]
                   != q.cfg[dcc_pkg::CFG_GAIN6_BIT]) begin
                  d.shift_a = wd[dcc_pkg::CFG_GAIN6_BIT] ? SHIFT_A_G6
                                                         : SHIFT_A_G4;
                  d.shift_b = wd[dcc_pkg::CFG_GAIN6_BIT] ? SHIFT_B_G6
                                                         : SHIFT_B_G4;
               end
            end
            dcc_pkg::ADDR_SHIFT_A: d.shift_a = dcc_fmt(wd, btc);
            dcc_pkg::ADDR_SHIFT_B: d.shift_b = dcc_fmt(wd, btc);
            default: d.rvalid = d.rvalid;
         endcase
      end

      // Engine off: no channel is taken, pending work is dropped.
      if (!en) begin
         d.cnt = '0;
         d.pend = '0;
         d.phase = dcc_pkg::DCC_IDLE;
      end
   end

   // -----------------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.cfg <= dcc_pkg::CONFIG_RESET;
         for (int i = 0; i < dcc_pkg::NCH; i++) begin
            q.input_raw[i] <= dcc_pkg::INPUT_RESET;
            q.gain[i] <= dcc_pkg::GAIN_RESET;
            q.zero[i] <= dcc_pkg::ZERO_RESET;
            q.data[i] <= dcc_pkg::DATA_RESET;
         end
         q.shift_a <= SHIFT_A_G6;
         q.shift_b <= SHIFT_B_G6;
         q.phase <= dcc_pkg::DCC_IDLE;
      end else begin
         q <= d;
      end
   end

   // -----------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------
   assign avs_rsp.readdata = q.rdata;
   assign avs_rsp.waitrequest = avs_req.read && !q.rvalid;
   assign conv.chan_code = q.data;
   assign conv.shift_code_a = q.shift_a;
   assign conv.shift_code_b = q.shift_b;
   assign conv.gain_six = q.cfg[dcc_pkg::CFG_GAIN6_BIT];
   assign conv.calib_engine_enable = en;
   assign conv.engine_busy = (q.phase == dcc_pkg::DCC_CALC) || (q.cnt != '0);

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence input_wr_s;
      chan_wr && region == dcc_pkg::REGION_INPUT;
   endsequence

   sequence gain_zero_wr_s;
      chan_wr && (region == dcc_pkg::REGION_GAIN
                  || region == dcc_pkg::REGION_ZERO);
   endsequence

   bypass_input_a: assert property (
      input_wr_s and !en
      |=> q.data[$past(wr_ch)] == dcc_fmt($past(wd), $past(btc)))
      else $error("bypass write did not reach data register");

   calc_result_a: assert property (
      q.phase == dcc_pkg::DCC_CALC && en && !$changed(q.fmt_s2)
      |=> q.data[$past(q.cur_ch)]
          == dcc_correct(dcc_fmt($past(q.input_raw[q.cur_ch]), $past(btc)),
                         $past(q.gain[q.cur_ch]), $past(q.zero[q.cur_ch])))
      else $error("corrected code mismatch");

   no_calc_a: assert property (
      gain_zero_wr_s and !en |=> q.phase == dcc_pkg::DCC_IDLE && q.cnt == '0
                                 && q.data == $past(q.data))
      else $error("gain or zero write started engine while off");

   shift_reload_a: assert property (
      $changed(q.cfg[dcc_pkg::CFG_GAIN6_BIT])
      |-> q.shift_a == (q.cfg[dcc_pkg::CFG_GAIN6_BIT] ? SHIFT_A_G6
                                                       : SHIFT_A_G4)
          && q.shift_b == (q.cfg[dcc_pkg::CFG_GAIN6_BIT] ? SHIFT_B_G6
                                                         : SHIFT_B_G4))
      else $error("shift code not reloaded on gain change");

   single_update_a: assert property (
      q.phase == dcc_pkg::DCC_IDLE
      && !(chan_wr && region == dcc_pkg::REGION_INPUT && !en)
      |=> $stable(q.data))
      else $error("data changed without engine step");

   queue_drain_a: assert property (
      $rose(q.pend[0]) && en ##1 en[*2] |-> ##[0:16] !q.pend[0] || !en)
      else $error("queued channel not served in time");

   disable_flush_a: assert property (
      !en |=> q.cnt == '0 && q.pend == '0 && q.phase == dcc_pkg::DCC_IDLE)
      else $error("engine active while disabled");

   sat_low_a: assert property (
      q.phase == dcc_pkg::DCC_CALC && en
      && q.zero[q.cur_ch] == 12'h800 && q.gain[q.cur_ch] == 12'h000
      && dcc_fmt(q.input_raw[q.cur_ch], btc) < 12'hFFF && !$changed(q.fmt_s2)
      |=> q.data[$past(q.cur_ch)] == 12'h000)
      else $error("negative corrected code not clamped to zero");

endmodule

// ==== core/dcc_pkg.sv ====
// Shared constants, register map and carrier types of the correction engine.
// Assumes a single 10 MHz clock and an Avalon-MM master on the register port.
package dcc_pkg;

   // ----------------------------------------------------------------------
   // Widths and counts
   // ----------------------------------------------------------------------
   localparam int NCH = 8;
   localparam int CW = 12;
   localparam int QW = 4;
   localparam int PROD_SHIFT = 12;

   // ----------------------------------------------------------------------
   // Register region codes and byte offsets
   // ----------------------------------------------------------------------
   localparam logic [2:0] REGION_INPUT = 3'h0;
   localparam logic [2:0] REGION_GAIN = 3'h1;
   localparam logic [2:0] REGION_ZERO = 3'h2;
   localparam logic [2:0] REGION_DATA = 3'h3;
   localparam logic [7:0] ADDR_CONFIG = 8'h80;
   localparam logic [7:0] ADDR_SHIFT_A = 8'h84;
   localparam logic [7:0] ADDR_SHIFT_B = 8'h88;
   localparam logic [7:0] ADDR_STATUS = 8'h8C;

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_GAIN6_BIT = 1;
   localparam logic [1:0] CONFIG_RESET = 2'h3;
   localparam logic [11:0] GAIN_RESET = 12'h800;
   localparam logic [11:0] ZERO_RESET = 12'h000;
   localparam logic [11:0] INPUT_RESET = 12'h000;
   localparam logic [11:0] DATA_RESET = 12'h000;
   localparam logic [12:0] GAIN_BIAS = 13'h0800;
   localparam logic [11:0] CODE_MAX = 12'hFFF;
   localparam logic [11:0] SHIFT_G6_DEFAULT = 12'h99A;
   localparam logic [11:0] SHIFT_G4_DEFAULT = 12'hAAB;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic {DCC_IDLE, DCC_CALC} dcc_phase_type;

   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } dcc_avs_req_type;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } dcc_avs_rsp_type;

   typedef struct packed {
      logic [NCH-1:0][CW-1:0] chan_code;
      logic [CW-1:0] shift_code_a;
      logic [CW-1:0] shift_code_b;
      logic gain_six;
      logic calib_engine_enable;
      logic engine_busy;
   } dcc_conv_type;

   typedef struct packed {
      logic fmt_s1;
      logic fmt_s2;
      logic [1:0] cfg;
      logic [NCH-1:0][CW-1:0] input_raw;
      logic [NCH-1:0][CW-1:0] gain;
      logic [NCH-1:0][CW-1:0] zero;
      logic [NCH-1:0][CW-1:0] data;
      logic [CW-1:0] shift_a;
      logic [CW-1:0] shift_b;
      logic [NCH-1:0][2:0] queue;
      logic [QW-1:0] cnt;
      logic [NCH-1:0] pend;
      dcc_phase_type phase;
      logic [2:0] cur_ch;
      logic rvalid;
      logic [31:0] rdata;
   } dcc_state_type;

endpackage

// ==== sim/dcc_host.sv ====
// Avalon-MM host model that drives the register port of the engine.
// Assumes the bench calls its tasks from one process, at rising edges.
`timescale 1ns/100ps
module dcc_host (
   // Clock
   input wire logic clk,
   // Register bus
   output dcc_pkg::dcc_avs_req_type req,
   input wire dcc_pkg::dcc_avs_rsp_type rsp
);
   initial begin
      req = '0;
   end

   // ----------------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------------
   // The request stays up after acceptance so that a caller may chain the
   // next one at the same edge; idle releases it.
   task automatic xfer(input logic [7:0] a, input logic is_rd,
                       input logic [11:0] d, output logic [31:0] q,
                       output bit ok);
      int n;
      req <= '{address: a, read: is_rd, write: !is_rd,
               writedata: {20'h00000, d}, byteenable: 4'hF};
      ok = 1'b0;
      q = '0;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge clk);
         ok = (rsp.waitrequest === 1'b0);
      end
      q = rsp.readdata;
   endtask

   task automatic idle();
      req <= '0;
   endtask
endmodule

// ==== sim/dac_calibration_correction_engine_test.sv ====
// Self-checking bench of the correction engine against an integer model.
// Assumes the host model in dcc_host and a free-running 10 MHz clock.
`timescale 1ns/100ps
module dac_calibration_correction_engine_test;
   logic clk;
   logic rst_b;
   logic format_select_pin;
   dcc_pkg::dcc_avs_req_type avs_req;
   dcc_pkg::dcc_avs_rsp_type avs_rsp;
   dcc_pkg::dcc_conv_type conv;
   int err_total;
   int n_compared;
   logic [31:0] seed;
   logic [31:0] rd_q;
   logic [31:0] r;
   bit ok;
   bit m_en;
   bit m_fmt;
   int m_in [8];
   int m_gain [8];
   int m_zero [8];
   int m_code [8];

   initial begin
      clk = 1'b0;
   end
   always #50 clk = ~clk;

   dcc_engine DUT (.clk(clk), .rst_b(rst_b), .avs_req(avs_req),
      .avs_rsp(avs_rsp), .format_select_pin(format_select_pin),
      .conv(conv));
   dcc_host host (.clk(clk), .req(avs_req), .rsp(avs_rsp));

   // ----------------------------------------------------------------------
   // Model and helpers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic int corr(int ch);
      int v;
      v = m_in[ch] * (m_gain[ch] + 2048) / 4096;
      v = v + (m_zero[ch] >= 2048 ? m_zero[ch] - 4096 : m_zero[ch]);
      return v < 0 ? 0 : (v > 4095 ? 4095 : v);
   endfunction

   task automatic report_and_stop();
      $display("Compared %0d values, %0d mismatches", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stuck();
      err_total++;
      report_and_stop();
   endtask

   task automatic wr(input logic [7:0] a, input logic [11:0] d);
      host.xfer(a, 1'b0, d, rd_q, ok);
      if (!ok) stuck();
   endtask

   task automatic rd(input logic [7:0] a);
      host.xfer(a, 1'b1, 12'h000, rd_q, ok);
      if (!ok) stuck();
   endtask

   // Kind 0 is input, 1 gain, 2 zero; the model mirrors the register file.
   task automatic put(input int ch, input int kind, input logic [11:0] d);
      wr({kind[2:0], ch[2:0], 2'b00}, d);
      if (kind == 0) m_in[ch] = m_fmt ? int'(d ^ 12'h800) : int'(d);
      if (kind == 1) m_gain[ch] = d;
      if (kind == 2) m_zero[ch] = d;
      if (m_en) m_code[ch] = corr(ch);
      else if (kind == 0) m_code[ch] = m_in[ch];
   endtask

   task automatic settle();
      int n;
      host.idle();
      for (n = 0; n < 60; n++) begin
         @(posedge clk);
         if (conv.engine_busy === 1'b0) break;
      end
      if (n == 60) stuck();
      for (n = 0; n < 8; n++) begin
         chk(conv.chan_code[n], m_code[n]);
      end
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      format_select_pin = 1'b0;
      rst_b = 1'b0;
      seed = 32'hAB06;
      err_total = 0;
      n_compared = 0;
      m_en = 1'b1;
      m_fmt = 1'b0;
      for (int c = 0; c < 8; c++) begin
         m_in[c] = 0;
         m_gain[c] = 2048;
         m_zero[c] = 0;
         m_code[c] = 0;
      end
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 3; k++) begin
         for (int c = 0; c < 8; c++) begin
            rd({k[2:0], c[2:0], 2'b00});
            chk(rd_q, k == 1 ? 32'h00000800 : 32'h00000000);
         end
      end
      rd(dcc_pkg::ADDR_CONFIG);
      chk(rd_q, 32'h00000003);
      rd(8'h90);
      chk(rd_q, 32'h00000000);
      chk(conv.shift_code_a, 12'h99A);
      chk(conv.shift_code_b, 12'h99A);
      put(1, 0, 12'hFFF);
      put(1, 1, 12'hFFF);
      put(1, 2, 12'h7FF);
      put(2, 0, 12'h100);
      put(2, 1, 12'h000);
      put(2, 2, 12'h800);
      put(5, 0, 12'h800);
      put(5, 1, 12'h000);
      settle();
      for (int c = 0; c < 8; c++) put(c, 0, 12'(rnd()));
      settle();
      repeat (30) begin
         r = rnd();
         put(r[2:0], r[4:3] == 2'h3 ? 0 : r[4:3], r[27:16]);
         if (r[8]) settle();
      end
      settle();
      wr(dcc_pkg::ADDR_CONFIG, 12'h002);
      m_en = 1'b0;
      put(3, 0, 12'h5A5);
      host.idle();
      @(posedge clk);
      chk(conv.chan_code[3], 12'h5A5);
      chk(conv.calib_engine_enable, 1'b0);
      put(3, 1, 12'h123);
      put(3, 2, 12'h456);
      settle();
      rd(8'h2C);
      chk(rd_q, 32'h00000123);
      rd(8'h4C);
      chk(rd_q, 32'h00000456);
      wr(dcc_pkg::ADDR_CONFIG, 12'h003);
      m_en = 1'b1;
      put(3, 0, 12'h5A5);
      host.idle();
      @(posedge clk);
      chk(conv.engine_busy, 1'b1);
      chk(conv.calib_engine_enable, 1'b1);
      settle();
      wr(dcc_pkg::ADDR_CONFIG, 12'h001);
      host.idle();
      @(posedge clk);
      chk(conv.gain_six, 1'b0);
      chk(conv.shift_code_a, 12'hAAB);
      chk(conv.shift_code_b, 12'hAAB);
      wr(dcc_pkg::ADDR_CONFIG, 12'h003);
      host.idle();
      @(posedge clk);
      chk(conv.shift_code_a, 12'h99A);
      format_select_pin <= 1'b1;
      m_fmt = 1'b1;
      repeat (3) @(posedge clk);
      put(6, 0, 12'h000);
      put(6, 1, 12'hC00);
      settle();
      rd(8'h18);
      chk(rd_q, 32'h00000000);
      rd(dcc_pkg::ADDR_SHIFT_A);
      chk(rd_q, 32'h0000019A);
      wr(dcc_pkg::ADDR_SHIFT_B, 12'h123);
      rd(dcc_pkg::ADDR_SHIFT_B);
      chk(rd_q, 32'h00000123);
      chk(conv.shift_code_b, 12'h923);
      rd(dcc_pkg::ADDR_STATUS);
      chk(rd_q, 32'h00000020);
      host.idle();
      report_and_stop();
   end
endmodule
